//--- testbench/fail_safe_output_control_test.sv
`include "fsafe_regs.svh"
`default_nettype none
module fail_safe_output_control_test
    import fsafe_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 0, rst = 1, low_power_off_state = 0, good = 0, bad = 0, key_wr = 0, sw_wr = 0, sw_req = 0;
    logic [14:0] cause = 15'h0000;
    logic init_ph = 1'b1, cfg_wr = 1'b0, ecc_clr = 1'b0;
    logic [19:0] cfg_data = 20'h0_1FFF;
    logic [25:0] upset = 26'h000_0000;
    logic [7:0] seed = 8'hA5;
    logic [2:0] op = 3'h0;
    logic [2:0] cnt;
    key_t key;
    logic rst_n, pri, sec, sw, eng, e1, e2;
    int n_mismatch = 0, tests_run = 0;
    // 25 MHz clock
    always #20 clk = ~clk;
    mcu_model host_u (.i_seed(seed), .i_op(op), .o_key(key));
    fail_safe_output_control #(.TICK_CYCLES(4)) dut_u (
        .i_ref_clk(clk), .i_rst(rst), .i_low_power_off_state_resume(low_power_off_state), .i_safety_init_phase(init_ph),
        .i_cfg_wr(cfg_wr), .i_cfg_data(cfg_data), .i_cfg_upset_mask(upset),
        .i_wd_err_max(cause[0]), .i_supply_uv(cause[1]), .i_supply_ov(cause[2]),
        .i_core_mon_fault(cause[3]), .i_io23_err(cause[4]), .i_io45_err(cause[5]),
        .i_pre_regulator_ov(cause[6]), .i_init_wd_fail(cause[7]),
        .i_logic_selftest_fail(cause[8]), .i_analog_selftest_fail(cause[9]),
        .i_reset_stuck_high(cause[10]), .i_secondary_stuck_high(cause[11]),
        .i_primary_stuck_high(cause[12]), .i_spi_reset_req(cause[13]),
        .i_spi_primary_low_req(cause[14]), .i_wd_good(good), .i_wd_bad(bad),
        .i_watchdog_seed_value(seed), .i_release_key_wr(key_wr),
        .i_safe_output_release_key(key), .i_backup_switch_req_wr(sw_wr),
        .i_backup_delay_switch_request(sw_req), .i_secondary_selftest_pass(1'b1),
        .i_aux_selftest_pass(1'b1), .i_aux_overvoltage_impact(2'h0),
        .i_aux_undervoltage_impact(2'h0), .i_ecc_flag_clr(ecc_clr),
        .o_reset_out_low(rst_n), .o_fail_safe_out_primary(pri), .o_fail_safe_out_secondary(sec),
        .o_backup_supply_switch(sw), .o_backup_delay_engaged_flag(eng), .o_fault_count(cnt),
        .o_ecc_single_flag(e1), .o_ecc_double_flag(e2));
    task automatic end_sim();
        if (n_mismatch == 0 && tests_run > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    task automatic check(input string nm, input logic [7:0] exp, input logic [7:0] got);
        tests_run++;
        if (got !== exp) begin
            $display("unexpected %s expected %0h seen %0h", nm, exp, got);
            n_mismatch++;
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(negedge clk);
    endtask
    // Fault pulse, answer settled two cycles later
    task automatic pulse_cause(input int idx);
        cause[idx] = 1'b1;
        tick(1);
        cause[idx] = 1'b0;
        tick(2);
    endtask
    task automatic refresh(input int n);
        repeat (n) begin
            good = 1'b1;
            tick(1);
            good = 1'b0;
            tick(1);
        end
    endtask
    // Action code is set just before the word is written
    task automatic release_out(input logic [2:0] code);
        op = code;
        key_wr = 1'b1;
        tick(1);
        key_wr = 1'b0;
        tick(2);
    endtask
    task automatic switch_req(input logic close);
        sw_req = close;
        sw_wr = 1'b1;
        tick(1);
        sw_wr = 1'b0;
        tick(2);
    endtask
    task automatic test_powerup();
        check("count", 8'h01, cnt);
        check("primary", 8'h00, pri);
        check("switch", 8'h00, sw);
        release_out(`KEY_OP_PRI);
        check("early primary", 8'h00, pri);
        refresh(6);
        check("count six", 8'h01, cnt);
        refresh(1);
        check("count seven", 8'h00, cnt);
        switch_req(1'b1);
        check("switch closed", 8'h01, sw);
        release_out(`KEY_OP_PRI);
        check("primary free", 8'h01, pri);
    endtask
    task automatic test_fixed_fault();
        seed = 8'h3C;
        pulse_cause(14);
        check("primary low", 8'h00, pri);
        check("secondary low", 8'h00, sec);
        check("count up", 8'h01, cnt);
        switch_req(1'b0);
        check("engaged", 8'h01, eng);
        refresh(3);
        bad = 1'b1;
        tick(1);
        bad = 1'b0;
        refresh(6);
        check("count after bad", 8'h01, cnt);
        refresh(1);
        release_out(3'h7);
        check("bad word", 8'h00, pri);
        release_out(`KEY_OP_BOTH);
        check("switch open", 8'h00, pri);
        switch_req(1'b1);
        release_out(`KEY_OP_BOTH);
        check("both primary", 8'h01, pri);
        check("both secondary", 8'h01, sec);
        check("engaged clear", 8'h00, eng);
        switch_req(1'b0);
        check("open refused", 8'h01, sw);
    endtask
    task automatic test_reset_cause();
        cause[13] = 1'b1;
        tick(2);
        check("reset low", 8'h00, rst_n);
        cause[13] = 1'b0;
        tick(2);
        check("reset high", 8'h01, rst_n);
        check("count reset", 8'h01, cnt);
        low_power_off_state = 1'b1;
        tick(1);
        low_power_off_state = 1'b0;
        tick(2);
        check("resume primary", 8'h00, pri);
    endtask
    // Primary first, then secondary with a fresh seed
    task automatic test_split_release();
        refresh(7);
        release_out(`KEY_OP_PRI);
        check("split primary", 8'h02, {pri, sec});
        seed = 8'h5A;
        release_out(`KEY_OP_SEC);
        check("split secondary", 8'h03, {pri, sec});
    endtask
    // Ten millisecond code: delay mode holds low, duration mode pulses
    task automatic test_timed(input logic dur);
        refresh(7);
        release_out(`KEY_OP_BOTH);
        check("timed start", 8'h03, {pri, sec});
        cfg_data = {6'h01, dur, 13'h1FFF};
        cfg_wr = 1'b1;
        tick(1);
        cfg_wr = 1'b0;
        pulse_cause(14);
        check("timed early", {7'h00, ~dur}, sec);
        tick(36);
        check("timed mid", {7'h00, ~dur}, sec);
        tick(2);
        check("timed end", {7'h00, dur}, sec);
    endtask
    // Upsets after init: one bit corrected, two bits assert the primary
    task automatic test_ecc();
        refresh(7);
        release_out(`KEY_OP_PRI);
        init_ph = 1'b0;
        upset = 26'h000_0008;
        tick(1);
        upset = 26'h000_0000;
        tick(1);
        check("single flag", 8'h01, e1);
        check("single only", 8'h00, e2);
        check("single silent", 8'h01, pri);
        ecc_clr = 1'b1;
        tick(1);
        ecc_clr = 1'b0;
        check("single clear", 8'h00, e1);
        upset = 26'h000_0018;
        tick(1);
        upset = 26'h000_0000;
        tick(1);
        check("double flag", 8'h01, e2);
        check("double primary", 8'h00, pri);
    endtask
    // Hang guard
    initial begin
        repeat (20000) @(posedge clk);
        n_mismatch++;
        end_sim();
    end
    initial begin
        tick(6);
        rst = 1'b0;
        tick(1);
        test_powerup();
        test_fixed_fault();
        test_reset_cause();
        test_split_release();
        test_timed(1'b0);
        test_timed(1'b1);
        test_ecc();
        end_sim();
    end
endmodule
`default_nettype wire

//--- testbench/mcu_model.sv
`default_nettype none
module mcu_model
    import fsafe_pkg::*;
(
    // Seed and chosen action
    input  wire logic [7:0] i_seed,
    input  wire logic [2:0] i_op,
    // Release word
    output var  key_t       o_key
);
    timeunit 1ns;
    timeprecision 1ps;
    // Action codes 3, 6, 5 over reversed, inverted seed bits, others over plain seed bits 4:0
    always_comb begin
        case (i_op)
            3'h3: o_key = {i_op, ~i_seed[0], ~i_seed[1], ~i_seed[2], ~i_seed[3], ~i_seed[4]};
            3'h6: o_key = {i_op, ~i_seed[3], ~i_seed[4], ~i_seed[5], ~i_seed[6], ~i_seed[7]};
            3'h5: o_key = {i_op, ~i_seed[0], ~i_seed[1], ~i_seed[2], ~i_seed[6], ~i_seed[7]};
            default: o_key = {i_op, i_seed[4:0]};
        endcase
    end
endmodule
`default_nettype wire

//--- verilog/cfg_hamming_guard.sv
`default_nettype none
module cfg_hamming_guard #(
    parameter int          DATA_W = 20,
    parameter int          PAR_W  = 5,
    parameter logic [19:0] RST_VAL = 20'h0_0000
) (
    // Clock and reset
    input  wire logic                    i_ref_clk,
    input  wire logic                    i_rst,
    // Write side
    input  wire logic                    i_init_phase,
    input  wire logic                    i_wr_en,
    input  wire logic [DATA_W-1:0]       i_wr_data,
    input  wire logic [DATA_W+PAR_W:0]   i_upset_mask,
    // Checked contents
    output logic      [DATA_W-1:0]       o_data,
    output logic                         o_single,
    output logic                         o_double
);
    localparam int N = DATA_W + PAR_W;

    // Parity count must cover all codeword positions
    if ((1 << PAR_W) < N + 1 || DATA_W > 20) begin : g_chk
        $error("cfg_hamming_guard: parity too narrow");
    end

    function automatic logic [N:0] encode(input logic [DATA_W-1:0] d);
        logic [N:0] c;
        int         j;
        c = '0;
        j = 0;
        for (int i = 1; i <= N; i++) begin
            if ((i & (i - 1)) != 0) begin
                c[i] = d[j];
                j++;
            end
        end
        for (int k = 0; k < PAR_W; k++) begin
            for (int i = 1; i <= N; i++) begin
                if (((i >> k) & 1) == 1 && i != (1 << k)) c[1 << k] ^= c[i];
            end
        end
        c[0] = ^c[N:1];
        return c;
    endfunction

    function automatic logic [DATA_W-1:0] extract(input logic [N:0] c);
        logic [DATA_W-1:0] d;
        int                j;
        d = '0;
        j = 0;
        for (int i = 1; i <= N; i++) begin
            if ((i & (i - 1)) != 0) begin
                d[j] = c[i];
                j++;
            end
        end
        return d;
    endfunction

    function automatic logic [PAR_W-1:0] syndrome(input logic [N:0] c);
        logic [PAR_W-1:0] s;
        s = '0;
        for (int k = 0; k < PAR_W; k++) begin
            for (int i = 1; i <= N; i++) begin
                if (((i >> k) & 1) == 1) s[k] ^= c[i];
            end
        end
        return s;
    endfunction

    localparam logic [N:0] CW_RST = encode(RST_VAL[DATA_W-1:0]);

    logic [N:0]       cw_q, cw_d, fix;
    logic [PAR_W-1:0] syn;
    logic             odd;

    // Check, correct and rewrite the stored codeword
    always_comb begin
        syn      = syndrome(cw_q);
        odd      = ^cw_q;
        fix      = odd ? ({{N{1'b0}}, 1'b1} << syn) : '0;
        o_single = !i_init_phase && odd;
        o_double = !i_init_phase && !odd && syn != '0;
        o_data   = extract(cw_q ^ fix);
        if (i_init_phase) begin
            cw_d = i_wr_en ? encode(i_wr_data) : cw_q;
        end else begin
            cw_d = cw_q ^ fix;
        end
        cw_d = cw_d ^ i_upset_mask;
    end

    always_ff @(posedge i_ref_clk or posedge i_rst) begin
        if (i_rst) cw_q <= CW_RST;
        else       cw_q <= cw_d;
    end
endmodule
`default_nettype wire

//--- verilog/fail_safe_output_control.sv
// Overview of operation
// - Power-up or low-power-off resume presets fault counter to 1, primary asserted.
// - With threshold 6, seven good refreshes bring the counter from 1 to 0.
// - Init config enables reset assertion per configurable fault cause except the IO45 error.
// - Reset always asserts on pre-regulator OV, init watchdog fail, stuck primary, SPI.
// - Init config enables primary output assertion per configurable fault cause.
// - Primary always asserts on pre-regulator OV, init watchdog fail, self-test fails, stuck reset or secondary, SPI, ECC.
// - Secondary follows primary, in delayed mode or fixed-duration mode.
// - Delayed mode: secondary low after programmed delay, held until software release.
// - Delay 0 to 3150 ms from four-bit code and range bit, counted digitally.
// - Zero delay in delayed mode asserts secondary in the same cycle as the primary.
// - Backup switch opens at reset; must be closed before secondary release.
// - Opening the backup switch is accepted only while primary is asserted.
// - Duration mode: secondary pulses low with primary for programmed time.
// - Release needs secondary self-test passed, aux self-test passed or no aux impact, fault gone, counter zero, switch if engaged, valid word.
// - Word top bits 011, 110, 101 select primary, secondary or both.
// - Safety config writable during init, Hamming protected afterwards.
// - Single bit error corrected silently and flagged.
// - Double bit error flagged and asserts the primary output.
// - Counter increments by one in each cycle where a reset or primary assertion starts (both at once count once), up to 7.
// - Good refreshes counted; next good after threshold decrements; bad clears.
// - Intermediate fault threshold 3 or 1 selected by one config bit.
`include "fsafe_regs.svh"
`default_nettype none
module fail_safe_output_control
    import fsafe_pkg::*;
#(
    parameter int unsigned TICK_CYCLES   = `TICK_TIME_NS / `CLK_PERIOD_NS,
    parameter int unsigned REFRESH_THR   = `REFRESH_THR_DEF,
    parameter int unsigned HAS_SECONDARY = 1
) (
    // Clock and reset
    input  wire logic                           i_ref_clk,
    input  wire logic                           i_rst,
    input  wire logic                           i_low_power_off_state_resume,
    // Safety configuration
    input  wire logic                           i_safety_init_phase,
    input  wire logic                           i_cfg_wr,
    input  wire logic [`CFG_W-1:0]              i_cfg_data,
    input  wire logic [`CFG_W+`CFG_PAR_W:0]     i_cfg_upset_mask,
    // Configurable fault causes
    input  wire logic                           i_wd_err_max,
    input  wire logic                           i_supply_uv,
    input  wire logic                           i_supply_ov,
    input  wire logic                           i_core_mon_fault,
    input  wire logic                           i_io23_err,
    input  wire logic                           i_io45_err,
    // Fixed fault causes
    input  wire logic                           i_pre_regulator_ov,
    input  wire logic                           i_init_wd_fail,
    input  wire logic                           i_logic_selftest_fail,
    input  wire logic                           i_analog_selftest_fail,
    input  wire logic                           i_reset_stuck_high,
    input  wire logic                           i_secondary_stuck_high,
    input  wire logic                           i_primary_stuck_high,
    input  wire logic                           i_spi_reset_req,
    input  wire logic                           i_spi_primary_low_req,
    // Watchdog
    input  wire logic                           i_wd_good,
    input  wire logic                           i_wd_bad,
    input  wire logic [7:0]                     i_watchdog_seed_value,
    // Release and backup switch
    input  wire logic                           i_release_key_wr,
    input  wire key_t                           i_safe_output_release_key,
    input  wire logic                           i_backup_switch_req_wr,
    input  wire logic                           i_backup_delay_switch_request,
    input  wire logic                           i_secondary_selftest_pass,
    input  wire logic                           i_aux_selftest_pass,
    input  wire logic [1:0]                     i_aux_overvoltage_impact,
    input  wire logic [1:0]                     i_aux_undervoltage_impact,
    input  wire logic                           i_ecc_flag_clr,
    // Outputs
    output logic                                o_reset_out_low,
    output logic                                o_fail_safe_out_primary,
    output logic                                o_fail_safe_out_secondary,
    output logic                                o_backup_supply_switch,
    output logic                                o_backup_delay_engaged_flag,
    output logic [2:0]                          o_fault_count,
    output logic                                o_ecc_single_flag,
    output logic                                o_ecc_double_flag
);
    localparam int PRE_W = (TICK_CYCLES < 2) ? 1 : $clog2(TICK_CYCLES);

    // Elaboration checks
    if (TICK_CYCLES < 2 || REFRESH_THR < 1 || REFRESH_THR > 14 || HAS_SECONDARY > 1)
    begin : g_chk
        $error("fail_safe_output_control: unsupported parameter");
    end

    logic [`CFG_W-1:0] cfg;
    logic              ecc_single, ecc_double;

    // Protected safety configuration
    cfg_hamming_guard #(
        .DATA_W  (`CFG_W),
        .PAR_W   (`CFG_PAR_W),
        .RST_VAL (`CFG_RESET)
    ) u_guard (
        .i_ref_clk    (i_ref_clk),
        .i_rst        (i_rst),
        .i_init_phase (i_safety_init_phase),
        .i_wr_en      (i_cfg_wr),
        .i_wr_data    (i_cfg_data),
        .i_upset_mask (i_cfg_upset_mask),
        .o_data       (cfg),
        .o_single     (ecc_single),
        .o_double     (ecc_double)
    );

    logic [2:0]  fc_q, fc_d, inter;
    logic [3:0]  rc_q, rc_d;
    logic        rst_q, pri_q, pri_d, sw_q, sw_d, eng_q, eng_d;
    logic        sgl_q, sgl_d, dbl_q, dbl_d, sec_low_q;
    logic        rst_cause, pri_cause, pri_set_ev, inc, dec;
    logic        cond_ok, key_pri, key_sec, pri_rel, sec_rel;
    logic [4:0]  exp_pri, exp_sec, exp_both;
    logic [11:0] dly_ms, ms_q, ms_d;
    logic [PRE_W-1:0] pre_q, pre_d;
    logic        tick;
    sec_state_e  sec_q, sec_d;

    // Fault causes and thresholds
    always_comb begin
        inter = cfg[`CFG_FLT_SEL] ? `FC_INTER_SHORT : `FC_INTER_LONG;
        rst_cause = |(cfg[`CFG_RST_EN_LSB +: `CFG_RST_EN_W] &
                      {fc_q >= inter, i_io23_err, i_core_mon_fault,
                       i_supply_ov, i_supply_uv, i_wd_err_max})
                  | i_pre_regulator_ov | i_init_wd_fail
                  | i_primary_stuck_high | i_spi_reset_req;
        pri_cause = |(cfg[`CFG_FS_EN_LSB +: `CFG_FS_EN_W] &
                      {fc_q >= inter, i_io45_err, i_io23_err, i_core_mon_fault,
                       i_supply_ov, i_supply_uv, i_wd_err_max})
                  | i_pre_regulator_ov | i_init_wd_fail | i_logic_selftest_fail
                  | i_analog_selftest_fail | i_reset_stuck_high
                  | i_secondary_stuck_high | i_spi_primary_low_req
                  | ecc_double;
        pri_set_ev = (pri_cause | i_low_power_off_state_resume) & ~pri_q;
        dly_ms = 12'(cfg[`CFG_TIME_LSB +: `CFG_TIME_W]) *
                 (cfg[`CFG_RANGE] ? 12'(`UNIT_COARSE_MS) : 12'(`UNIT_FINE_MS));
    end

    // Release word check against the current seed
    always_comb begin
        exp_pri  = ~{i_watchdog_seed_value[0], i_watchdog_seed_value[1],
                     i_watchdog_seed_value[2], i_watchdog_seed_value[3],
                     i_watchdog_seed_value[4]};
        exp_sec  = ~{i_watchdog_seed_value[3], i_watchdog_seed_value[4],
                     i_watchdog_seed_value[5], i_watchdog_seed_value[6],
                     i_watchdog_seed_value[7]};
        exp_both = ~{i_watchdog_seed_value[0], i_watchdog_seed_value[1],
                     i_watchdog_seed_value[2], i_watchdog_seed_value[6],
                     i_watchdog_seed_value[7]};
        cond_ok  = (HAS_SECONDARY == 0 || i_secondary_selftest_pass)
                && (i_aux_selftest_pass
                    || (i_aux_overvoltage_impact == 2'h0 && i_aux_undervoltage_impact == 2'h0))
                && !pri_cause && !rst_cause && fc_q == 3'h0
                && (!eng_q || sw_q);
        key_pri  = (i_safe_output_release_key[7:5] == `KEY_OP_PRI
                    && i_safe_output_release_key[4:0] == exp_pri)
                || (i_safe_output_release_key[7:5] == `KEY_OP_BOTH
                    && i_safe_output_release_key[4:0] == exp_both);
        key_sec  = (i_safe_output_release_key[7:5] == `KEY_OP_SEC
                    && i_safe_output_release_key[4:0] == exp_sec)
                || (i_safe_output_release_key[7:5] == `KEY_OP_BOTH
                    && i_safe_output_release_key[4:0] == exp_both);
        pri_rel  = i_release_key_wr && key_pri && cond_ok && pri_q;
        sec_rel  = i_release_key_wr && key_sec && cond_ok && sw_q
                && sec_q == SEC_LOW;
    end

    // Fault counter, refresh counter, outputs and switch next state
    always_comb begin
        inc  = (rst_cause & ~rst_q) | (pri_cause & ~pri_q);
        dec  = i_wd_good && rc_q == 4'(REFRESH_THR) && fc_q != 3'h0;
        fc_d = fc_q;
        if (inc && !dec && fc_q != `FC_MAX) fc_d = fc_q + 1'b1;
        else if (dec && !inc) fc_d = fc_q - 1'b1;
        if (i_low_power_off_state_resume) fc_d = `FC_START;
        rc_d = rc_q;
        if (i_wd_bad) rc_d = 4'h0;
        else if (i_wd_good) rc_d = (rc_q == 4'(REFRESH_THR)) ? 4'h0 : rc_q + 1'b1;
        pri_d = (pri_q & ~pri_rel) | pri_cause | i_low_power_off_state_resume;
        sw_d  = sw_q;
        eng_d = eng_q & ~(pri_rel | sec_rel);
        if (i_backup_switch_req_wr && i_backup_delay_switch_request) begin
            sw_d = 1'b1;
        end else if (i_backup_switch_req_wr && pri_q) begin
            sw_d  = 1'b0;
            eng_d = 1'b1;
        end
        sgl_d = ecc_single | (sgl_q & ~i_ecc_flag_clr);
        dbl_d = ecc_double | (dbl_q & ~i_ecc_flag_clr);
    end

    always_ff @(posedge i_ref_clk or posedge i_rst) begin
        if (i_rst) begin
            fc_q  <= `FC_START;
            rc_q  <= 4'h0;
            rst_q <= 1'b0;
            pri_q <= 1'b1;
            sw_q  <= 1'b0;
            eng_q <= 1'b0;
            sgl_q <= 1'b0;
            dbl_q <= 1'b0;
        end else begin
            fc_q  <= fc_d;
            rc_q  <= rc_d;
            rst_q <= rst_cause;
            pri_q <= pri_d;
            sw_q  <= sw_d;
            eng_q <= eng_d;
            sgl_q <= sgl_d;
            dbl_q <= dbl_d;
        end
    end

    // Secondary output sequencing with a one-millisecond tick
    always_comb begin
        sec_d = sec_q;
        ms_d  = ms_q;
        pre_d = pre_q;
        tick  = pre_q == PRE_W'(TICK_CYCLES - 1);
        unique case (sec_q)
            SEC_IDLE: begin
                if (pri_set_ev && HAS_SECONDARY != 0) begin
                    pre_d = '0;
                    ms_d  = dly_ms;
                    if (!cfg[`CFG_DUR_MODE]) begin
                        sec_d = (dly_ms == 12'h0) ? SEC_LOW : SEC_DELAY;
                    end else if (dly_ms != 12'h0) begin
                        sec_d = SEC_PULSE;
                    end
                end
            end
            SEC_DELAY, SEC_PULSE: begin
                pre_d = tick ? '0 : pre_q + 1'b1;
                if (tick) begin
                    ms_d = ms_q - 1'b1;
                    if (ms_q == 12'h1) begin
                        sec_d = (sec_q == SEC_DELAY) ? SEC_LOW : SEC_IDLE;
                    end
                end
            end
            SEC_LOW: begin
                if (sec_rel) sec_d = SEC_IDLE;
            end
        endcase
    end

    always_ff @(posedge i_ref_clk or posedge i_rst) begin
        if (i_rst) begin
            sec_q     <= SEC_IDLE;
            ms_q      <= 12'h0;
            pre_q     <= '0;
            sec_low_q <= 1'b0;
        end else begin
            sec_q     <= sec_d;
            ms_q      <= ms_d;
            pre_q     <= pre_d;
            sec_low_q <= sec_d == SEC_LOW || sec_d == SEC_PULSE;
        end
    end

    // Pin levels, reset and fail-safe outputs low when asserted
    assign o_reset_out_low             = ~rst_q;
    assign o_fail_safe_out_primary     = ~pri_q;
    assign o_fail_safe_out_secondary   = ~sec_low_q;
    assign o_backup_supply_switch      = sw_q;
    assign o_backup_delay_engaged_flag = eng_q;
    assign o_fault_count               = fc_q;
    assign o_ecc_single_flag           = sgl_q;
    assign o_ecc_double_flag           = dbl_q;

    // Checks
    default clocking cb @(posedge i_ref_clk); endclocking
    default disable iff (i_rst);

    a_resume_preset: assert property (i_low_power_off_state_resume |=>
        o_fault_count == `FC_START && !o_fail_safe_out_primary)
        else $error("resume did not preset counter and primary");
    a_fixed_reset: assert property ((i_pre_regulator_ov || i_spi_reset_req)
        |=> !o_reset_out_low) else $error("fixed reset cause ignored");
    a_fixed_primary: assert property ((i_logic_selftest_fail ||
        i_spi_primary_low_req || ecc_double) |=> !o_fail_safe_out_primary)
        else $error("fixed primary cause ignored");
    a_zero_delay: assert property ((pri_set_ev && !cfg[`CFG_DUR_MODE] &&
        dly_ms == 12'h0 && sec_q == SEC_IDLE && HAS_SECONDARY != 0) |=>
        !o_fail_safe_out_secondary && !o_fail_safe_out_primary)
        else $error("secondary not with primary at zero delay");
    a_bad_refresh: assert property (i_wd_bad |=> rc_q == 4'h0)
        else $error("bad refresh did not clear count");
    a_count_step: assert property ((inc && !dec && !i_low_power_off_state_resume &&
        fc_q != `FC_MAX) |=> fc_q == $past(fc_q) + 3'h1)
        else $error("fault counter did not step up");
    a_release_zero: assert property ($rose(o_fail_safe_out_primary) |->
        $past(fc_q) == 3'h0 && $past(i_release_key_wr))
        else $error("primary released with counter nonzero");
    a_wrong_key: assert property ((i_release_key_wr && !key_pri && !key_sec
        && !pri_cause && !i_low_power_off_state_resume) |=> $stable(o_fail_safe_out_primary) &&
        ($stable(o_fail_safe_out_secondary) || $past(sec_q) != SEC_LOW))
        else $error("wrong key changed an output");
    a_switch_test: assert property ((i_backup_switch_req_wr &&
        !i_backup_delay_switch_request && !pri_q) |=> $stable(sw_q))
        else $error("switch opened without primary asserted");
    a_sec_hold: assert property ((sec_q == SEC_LOW && !sec_rel) |=>
        !o_fail_safe_out_secondary) else $error("secondary left low state");

    c_release_pri: cover property (pri_rel);
    c_release_sec: cover property (sec_rel);
    c_pulse_end: cover property (sec_q == SEC_PULSE ##1 sec_q == SEC_IDLE);
    c_ecc_single: cover property (ecc_single);
endmodule
`default_nettype wire

//--- verilog/fsafe_pkg.sv
`default_nettype none
package fsafe_pkg;
    // Secondary fail-safe output sequencing
    typedef enum logic [1:0] {
        SEC_IDLE,
        SEC_DELAY,
        SEC_LOW,
        SEC_PULSE
    } sec_state_e;
    typedef logic [7:0] key_t;
endpackage
`default_nettype wire

//--- verilog/fsafe_regs.svh
`ifndef FSAFE_REGS_SVH
`define FSAFE_REGS_SVH

// Safety configuration word layout
`define CFG_W           20
`define CFG_PAR_W       5
`define CFG_RST_EN_LSB  0
`define CFG_RST_EN_W    6
`define CFG_FS_EN_LSB   6
`define CFG_FS_EN_W     7
`define CFG_DUR_MODE    13
`define CFG_TIME_LSB    14
`define CFG_TIME_W      4
`define CFG_RANGE       18
`define CFG_FLT_SEL     19
`define CFG_RESET       20'h0_1FFF

// Release word action codes, top three bits
`define KEY_OP_PRI      3'h3
`define KEY_OP_SEC      3'h6
`define KEY_OP_BOTH     3'h5

// Fault counter values
`define FC_START        3'h1
`define FC_MAX          3'h7
`define FC_INTER_LONG   3'h3
`define FC_INTER_SHORT  3'h1

// Good refresh threshold default
`define REFRESH_THR_DEF 6

// Timing: one delay step tick and the clock period
`define TICK_TIME_NS    1000000
`define CLK_PERIOD_NS   40
`define UNIT_FINE_MS    10
`define UNIT_COARSE_MS  210

`endif
